// >>> hdl/svil_core.sv
// interrupt request, priority and service logic around the shared vector
// Summary of operation
// (RQ1) shared flag sets whenever any member flag becomes set
// (RQ2) servicing shared vector clears shared flag and global enable
// (RQ3) member flags untouched by service; only software clears them
// (RQ4) timer a and c/adc flags set on overflow; vector needs both enables
// (RQ5) servicing timer a or c/adc clears its flag and global enable
// (RQ6) vector 18h source is timer c or adc, fixed by strap
// (RQ7) timer b flag vectors only with global, shared, own enable, stack free
// (RQ8) cmp a flag sets on output change; vector needs global and own enable
// (RQ9) servicing cmp a clears its flag and global enable
// (RQ10) cmp b/c flags set on change; need global, shared and own enable
// (RQ11) any flag rising wakes from power-down, enables ignored
// (RQ12) software sets a flag before power-down to mask its wake-up
// (RQ13) flags hold until serviced or cleared; enable only blocks service
// (RQ14) only the program counter is pushed on interrupt entry
// (RQ15) shared vector branches to 04h
// (RQ16) fixed priority: shared, cmp a, ext, timer a, timer c/adc
// (RQ17) requests are taken at the next t2 phase edge
// (RQ18) no acknowledge while stack is full
// (RQ19) all flags and enables are software readable and writable
`timescale 1ns/1ps
`include "svil_regs.svh"

module svil_core
	import svil_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       t2_edge,
	input  wire logic       stack_full,
	input  wire logic       src_sel_adc,
	input  wire logic       timer_a_ovf,
	input  wire logic       timer_b_ovf,
	input  wire logic       timer_c_ovf,
	input  wire logic       adc_done,
	input  wire logic       cmp_a_out,
	input  wire logic       cmp_b_out,
	input  wire logic       cmp_c_out,
	input  wire logic       ext_flag,
	input  wire logic       ext_enable,
	input  wire logic       sw_we,
	input  wire logic [8:0] sw_flag_wdata,
	input  wire logic [6:0] sw_en_wdata,
	output logic      [8:0] sw_flag_rdata,
	output logic      [6:0] sw_en_rdata,
	output logic            irq_take,
	output logic      [7:0] irq_vector,
	output logic            push_pc,
	output logic            ext_service,
	output logic            wake_up
);
	// flag order: 0 shared,1 ta,2 tb,3 tc/adc,4 ca,5 cb,6 cc
	// enable order: 0 global,1 shared,2 ta,3 tb,4 tc/adc,5 ca,6 cb
	// sw_flag bits 7..8 and enable cmp_c handled below

	logic shared_vector_flag;
	logic timer_a_ovf_flag;
	logic timer_b_ovf_flag;
	logic timer_c_or_adc_flag;
	logic cmp_a_change_flag;
	logic cmp_b_change_flag;
	logic cmp_c_change_flag;
	logic global_irq_enable;
	logic shared_vector_enable;
	logic timer_a_ovf_enable;
	logic timer_b_ovf_enable;
	logic timer_c_or_adc_enable;
	logic cmp_a_change_enable;
	logic cmp_b_change_enable;
	logic cmp_c_change_enable;
	logic src_adc;
	logic strap_done;
	logic cmp_a_q;
	logic cmp_b_q;
	logic cmp_c_q;
	logic [6:0] flags_q;
	svil_src_t next_src;

	// ---------------------------------------------------------------
	// source events
	// ---------------------------------------------------------------
	logic ev_ta;
	logic ev_tb;
	logic ev_tc;
	logic ev_ca;
	logic ev_cb;
	logic ev_cc;
	logic mem_shared;
	logic svc_shared;
	logic svc_ca;
	logic svc_ta;
	logic svc_tc;

	assign ev_ta = timer_a_ovf;                                     // see (RQ4)
	assign ev_tb = timer_b_ovf;                                     // see (RQ7)
	assign ev_tc = src_adc ? adc_done : timer_c_ovf;                // see (RQ6)
	assign ev_ca = cmp_a_out ^ cmp_a_q;                             // see (RQ8)
	assign ev_cb = cmp_b_out ^ cmp_b_q;                             // see (RQ10)
	assign ev_cc = cmp_c_out ^ cmp_c_q;                             // see (RQ10)

	// member enabled and pending feeds the shared request
	assign mem_shared = (timer_b_ovf_flag & timer_b_ovf_enable)
		| (cmp_b_change_flag & cmp_b_change_enable)
		| (cmp_c_change_flag & cmp_c_change_enable);                  // see (RQ7)

	// ---------------------------------------------------------------
	// priority
	// ---------------------------------------------------------------
	always_comb
	begin
		next_src = SVIL_SRC_NONE;
		if (global_irq_enable && !stack_full)                         // see (RQ18)
		begin
			if (shared_vector_flag && shared_vector_enable && mem_shared)
				next_src = SVIL_SRC_SHARED;                           // see (RQ16)
			else if (cmp_a_change_flag && cmp_a_change_enable)
				next_src = SVIL_SRC_CMP_A;                            // see (RQ8)
			else if (ext_flag && ext_enable)
				next_src = SVIL_SRC_EXT;
			else if (timer_a_ovf_flag && timer_a_ovf_enable)
				next_src = SVIL_SRC_TIMER_A;                          // see (RQ4)
			else if (timer_c_or_adc_flag && timer_c_or_adc_enable)
				next_src = SVIL_SRC_TIMER_C;
		end
	end

	// only sampled at the t2 phase edge
	assign svc_shared = t2_edge && next_src == SVIL_SRC_SHARED;        // see (RQ17)
	assign svc_ca     = t2_edge && next_src == SVIL_SRC_CMP_A;
	assign svc_ta     = t2_edge && next_src == SVIL_SRC_TIMER_A;
	assign svc_tc     = t2_edge && next_src == SVIL_SRC_TIMER_C;

	// ---------------------------------------------------------------
	// strap and comparator history
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			src_adc    <= 1'b0;
			strap_done <= 1'b0;
		end
		else if (!strap_done)
		begin
			// caught once after reset; software has no path to it
			src_adc    <= src_sel_adc;                                // see (RQ6)
			strap_done <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cmp_a_q <= 1'b0;
			cmp_b_q <= 1'b0;
			cmp_c_q <= 1'b0;
		end
		else
		begin
			cmp_a_q <= cmp_a_out;
			cmp_b_q <= cmp_b_out;
			cmp_c_q <= cmp_c_out;
		end
	end

	// ---------------------------------------------------------------
	// request flags: hardware set wins over any clear
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			shared_vector_flag  <= `SVIL_FLAG_RST;
			timer_a_ovf_flag    <= `SVIL_FLAG_RST;
			timer_b_ovf_flag    <= `SVIL_FLAG_RST;
			timer_c_or_adc_flag <= `SVIL_FLAG_RST;
			cmp_a_change_flag   <= `SVIL_FLAG_RST;
			cmp_b_change_flag   <= `SVIL_FLAG_RST;
			cmp_c_change_flag   <= `SVIL_FLAG_RST;
		end
		else
		begin
			if (ev_tb || ev_cb || ev_cc || (sw_we && (sw_flag_wdata[2]
				|| sw_flag_wdata[5] || sw_flag_wdata[6])))
				shared_vector_flag <= 1'b1;                           // see (RQ1)
			else if (svc_shared)
				shared_vector_flag <= 1'b0;                           // see (RQ2)
			else if (sw_we)
				shared_vector_flag <= sw_flag_wdata[0];               // see (RQ19)

			if (ev_ta)
				timer_a_ovf_flag <= 1'b1;
			else if (svc_ta)
				timer_a_ovf_flag <= 1'b0;                             // see (RQ5)
			else if (sw_we)
				timer_a_ovf_flag <= sw_flag_wdata[1];                 // see (RQ13)

			// member flags: no service clear
			if (ev_tb)
				timer_b_ovf_flag <= 1'b1;
			else if (sw_we)
				timer_b_ovf_flag <= sw_flag_wdata[2];                 // see (RQ3)

			if (ev_tc)
				timer_c_or_adc_flag <= 1'b1;
			else if (svc_tc)
				timer_c_or_adc_flag <= 1'b0;                          // see (RQ5)
			else if (sw_we)
				timer_c_or_adc_flag <= sw_flag_wdata[3];

			if (ev_ca)
				cmp_a_change_flag <= 1'b1;
			else if (svc_ca)
				cmp_a_change_flag <= 1'b0;                            // see (RQ9)
			else if (sw_we)
				cmp_a_change_flag <= sw_flag_wdata[4];

			if (ev_cb)
				cmp_b_change_flag <= 1'b1;
			else if (sw_we)
				cmp_b_change_flag <= sw_flag_wdata[5];                // see (RQ3)

			if (ev_cc)
				cmp_c_change_flag <= 1'b1;
			else if (sw_we)
				cmp_c_change_flag <= sw_flag_wdata[6];                // see (RQ3)
		end
	end

	// ---------------------------------------------------------------
	// enables: any service drops the global enable
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			global_irq_enable     <= `SVIL_EN_RST;
			shared_vector_enable  <= `SVIL_EN_RST;
			timer_a_ovf_enable    <= `SVIL_EN_RST;
			timer_b_ovf_enable    <= `SVIL_EN_RST;
			timer_c_or_adc_enable <= `SVIL_EN_RST;
			cmp_a_change_enable   <= `SVIL_EN_RST;
			cmp_b_change_enable   <= `SVIL_EN_RST;
			cmp_c_change_enable   <= `SVIL_EN_RST;
		end
		else
		begin
			if (t2_edge && next_src != SVIL_SRC_NONE)
				global_irq_enable <= 1'b0;                            // see (RQ2) (RQ5) (RQ9)
			else if (sw_we)
				global_irq_enable <= sw_en_wdata[0];                  // see (RQ19)
			if (sw_we)
			begin
				shared_vector_enable  <= sw_en_wdata[1];
				timer_a_ovf_enable    <= sw_en_wdata[2];
				timer_b_ovf_enable    <= sw_en_wdata[3];
				timer_c_or_adc_enable <= sw_en_wdata[4];
				cmp_a_change_enable   <= sw_en_wdata[5];
				cmp_b_change_enable   <= sw_en_wdata[6];
				cmp_c_change_enable   <= sw_flag_wdata[8];
			end
		end
	end

	// ---------------------------------------------------------------
	// outputs to the core
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irq_take    <= 1'b0;
			push_pc     <= 1'b0;
			ext_service <= 1'b0;
			irq_vector  <= 8'h00;
			flags_q     <= 7'h00;
			wake_up     <= 1'b0;
		end
		else
		begin
			irq_take    <= t2_edge && next_src != SVIL_SRC_NONE;
			// only the pc goes on the stack; isr saves anything else
			push_pc     <= t2_edge && next_src != SVIL_SRC_NONE;      // see (RQ14)
			ext_service <= t2_edge && next_src == SVIL_SRC_EXT;
			unique case (next_src)
				SVIL_SRC_NONE:    irq_vector <= 8'h00;
				SVIL_SRC_SHARED:  irq_vector <= `SVIL_VEC_SHARED;     // see (RQ15)
				SVIL_SRC_CMP_A:   irq_vector <= `SVIL_VEC_CMP_A;
				SVIL_SRC_EXT:     irq_vector <= `SVIL_VEC_EXT;
				SVIL_SRC_TIMER_A: irq_vector <= `SVIL_VEC_TIMER_A;
				SVIL_SRC_TIMER_C: irq_vector <= `SVIL_VEC_TIMER_C;
				default:          irq_vector <= 8'h00;
			endcase
			flags_q <= {cmp_c_change_flag, cmp_b_change_flag, cmp_a_change_flag,
				timer_c_or_adc_flag, timer_b_ovf_flag, timer_a_ovf_flag, shared_vector_flag};
			// flags preset by software cannot rise, so they stay silent
			wake_up <= |({cmp_c_change_flag, cmp_b_change_flag, cmp_a_change_flag,
				timer_c_or_adc_flag, timer_b_ovf_flag, timer_a_ovf_flag, shared_vector_flag}
				& ~flags_q);                                          // see (RQ11) (RQ12)
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sw_flag_rdata <= 9'h000;
			sw_en_rdata   <= 7'h00;
		end
		else
		begin
			sw_flag_rdata <= {cmp_c_change_enable, 1'b0, flags_q[6:0]};
			sw_en_rdata   <= {cmp_b_change_enable, cmp_a_change_enable,
				timer_c_or_adc_enable, timer_b_ovf_enable, timer_a_ovf_enable,
				shared_vector_enable, global_irq_enable};
		end
	end

endmodule // svil_core

// >>> shared/svil_regs.svh
// constants for the shared vector interrupt logic
`ifndef SVIL_REGS_SVH
`define SVIL_REGS_SVH
`define SVIL_VEC_SHARED  8'h04
`define SVIL_VEC_CMP_A   8'h08
`define SVIL_VEC_EXT     8'h0c
`define SVIL_VEC_TIMER_A 8'h14
`define SVIL_VEC_TIMER_C 8'h18
`define SVIL_FLAG_RST    1'b0
`define SVIL_EN_RST      1'b0
`endif

// >>> shared/svil_pkg.sv
// types for the shared vector interrupt logic
package svil_pkg;
	typedef enum logic [2:0] {
		SVIL_SRC_NONE,
		SVIL_SRC_SHARED,
		SVIL_SRC_CMP_A,
		SVIL_SRC_EXT,
		SVIL_SRC_TIMER_A,
		SVIL_SRC_TIMER_C
	} svil_src_t;
endpackage

// >>> sim/svil_core_assertions.sv
// port-level checks for the shared vector interrupt logic
`timescale 1ns/1ps
`include "svil_regs.svh"
module svil_core_assertions
(
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic       t2_edge,
	input wire logic       stack_full,
	input wire logic       timer_a_ovf,
	input wire logic       sw_we,
	input wire logic [8:0] sw_flag_rdata,
	input wire logic [6:0] sw_en_rdata,
	input wire logic       irq_take,
	input wire logic [7:0] irq_vector,
	input wire logic       push_pc,
	input wire logic       ext_service,
	input wire logic       wake_up
);
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	sequence s_granted;
		irq_take && push_pc;
	endsequence
	sequence s_member_rose;
		|(sw_flag_rdata[6:0] & ~$past(sw_flag_rdata[6:0]) & 7'h64);
	endsequence
	AST_TAKE_CAUSE:
		assert property (irq_take |-> $past(t2_edge) && !$past(stack_full))
		else $error("take without t2 edge or with stack full");
	AST_TAKE_GLOBAL:
		assert property (irq_take |-> sw_en_rdata[0])
		else $error("take while global enable off");
	AST_PUSH_ONLY:
		assert property (push_pc == irq_take)
		else $error("push does not match take");
	AST_VEC_LEGAL:
		assert property (irq_take |-> irq_vector inside {8'h04, 8'h08, 8'h0c, 8'h14, 8'h18})
		else $error("illegal vector");
	AST_EXT_VEC:
		assert property (ext_service |-> irq_take && irq_vector == `SVIL_VEC_EXT)
		else $error("external service without its vector");
	AST_GLOBAL_DROP:
		assert property (s_granted ##0 !$past(sw_we) |=> !sw_en_rdata[0] && !irq_take)
		else $error("global enable not cleared on service");
	AST_TA_CLEAR:
		// an overflow in the service cycle sets the flag again, and the set wins
		assert property (s_granted ##0 irq_vector == `SVIL_VEC_TIMER_A ##0 !$past(timer_a_ovf)
			|-> ##2 !sw_flag_rdata[1])
		else $error("timer a flag not cleared on service");
	AST_WAKE:
		assert property (|(sw_flag_rdata[6:0] & ~$past(sw_flag_rdata[6:0])) |-> $past(wake_up))
		else $error("flag rose without wake");
	AST_MEMBER_HOLD:
		assert property (|($past(sw_flag_rdata[6:0]) & ~sw_flag_rdata[6:0] & 7'h64) |-> $past(sw_we, 3))
		else $error("member flag fell without write");
	AST_SHARED_SET:
		assert property (s_member_rose |-> sw_flag_rdata[0])
		else $error("shared flag not set with member");
endmodule // svil_core_assertions

bind svil_core svil_core_assertions u_svil_core_assertions (.clk, .rst_n, .t2_edge,
	.stack_full, .timer_a_ovf, .sw_we, .sw_flag_rdata, .sw_en_rdata, .irq_take, .irq_vector,
	.push_pc, .ext_service, .wake_up);

// >>> sim/svil_stack_model.sv
// processor core stack model: counts pushed program counters
`timescale 1ns/1ps
module svil_stack_model #(parameter int DEPTH = 1)
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic push_pc,
	input  wire logic pop,
	output logic      stack_full
);
	int depth;
	// only the program counter goes on the stack, one slot per entry
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			depth <= 0;
		else
			depth <= depth + int'(push_pc) - int'(pop && depth > 0);
	assign stack_full = (depth >= DEPTH);
endmodule // svil_stack_model

// >>> sim/tb_top.sv
// self-checking bench for the shared vector interrupt logic
`timescale 1ns/1ps
`include "svil_regs.svh"
module tb_top;
	logic        clk = 0, rst_n = 0, t2_edge = 0, stack_full, pop = 0;
	logic        ta = 0, tb = 0, tc = 0, adc = 0, ca = 0, cb = 0, cc = 0;
	logic        ext_flag = 0, ext_enable = 0, sw_we = 0;
	logic [8:0]  sw_flag_wdata = 0, sw_flag_rdata, fl;
	logic [6:0]  sw_en_wdata = 0, sw_en_rdata;
	logic        irq_take, push_pc, ext_service, wake_up;
	logic [7:0]  irq_vector, v;
	logic [31:0] r;
	logic [8:0]  ef;
	logic [6:0]  en;
	logic        sel_adc = 0;
	int          errors = 0, n_tests = 0, i;
	always #12.5 clk = ~clk;
	svil_core u_svil_core (.clk, .rst_n, .t2_edge, .stack_full, .src_sel_adc(sel_adc),
		.timer_a_ovf(ta), .timer_b_ovf(tb), .timer_c_ovf(tc), .adc_done(adc),
		.cmp_a_out(ca), .cmp_b_out(cb), .cmp_c_out(cc), .ext_flag, .ext_enable,
		.sw_we, .sw_flag_wdata, .sw_en_wdata, .sw_flag_rdata, .sw_en_rdata,
		.irq_take, .irq_vector, .push_pc, .ext_service, .wake_up);
	svil_stack_model u_svil_stack_model (.clk, .rst_n, .push_pc, .pop, .stack_full);
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		if (errors == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic wr(input logic [8:0] f, input logic [6:0] e);
		@(negedge clk);
		sw_flag_wdata = f;
		sw_en_wdata = e;
		sw_we = 1;
		@(negedge clk);
		sw_we = 0;
	endtask
	// one t2 phase edge; a refused request must show nothing
	task automatic take(input logic [7:0] ev, input logic want);
		int k;
		@(negedge clk);
		t2_edge = 1;
		@(negedge clk);
		t2_edge = 0;
		for (k = 0; want && irq_take !== 1'b1; k++)
		begin
			if (k == 3)
			begin
				errors++;
				summarize();
			end
			@(negedge clk);
		end
		chk(irq_take, want);
		chk(push_pc, want);
		chk(irq_vector & {8{want}}, ev);
		chk(ext_service, want && ev == `SVIL_VEC_EXT);
	endtask
	// expected winner from flags, enables and the external request; 0 when none
	function automatic logic [7:0] vec(input logic [8:0] f, input logic [6:0] e, input logic x);
		if (!e[0])
			return 8'h00;
		if (f[0] && e[1] && ((f[2] && e[3]) || (f[5] && e[6]) || (f[6] && f[8])))
			return `SVIL_VEC_SHARED;
		if (f[4] && e[5])
			return `SVIL_VEC_CMP_A;
		if (x)
			return `SVIL_VEC_EXT;
		if (f[1] && e[2])
			return `SVIL_VEC_TIMER_A;
		if (f[3] && e[4])
			return `SVIL_VEC_TIMER_C;
		return 8'h00;
	endfunction
	// flag that service of a vector clears by hardware
	function automatic logic [8:0] svc(input logic [7:0] v);
		return v == `SVIL_VEC_SHARED ? 9'h001 : v == `SVIL_VEC_CMP_A ? 9'h010 :
			v == `SVIL_VEC_TIMER_A ? 9'h002 : v == `SVIL_VEC_TIMER_C ? 9'h008 : 9'h000;
	endfunction
	initial
	begin
		void'($urandom(91863));
		repeat (12) @(negedge clk);
		rst_n = 1;
		chk(sw_flag_rdata, 9'h000);
		chk(sw_en_rdata, 7'h00);
		// random events with every enable off: flags collect and hold
		fl = 0;
		for (i = 0; i < 24; i++)
		begin
			@(negedge clk);
			r = $urandom;
			{ta, tb, tc, adc} = {r[5] & r[9], r[4] & r[10], r[3] & r[11], r[12]};
			fl |= {2'b0, cc ^ r[2], cb ^ r[1], ca ^ r[0], tc, tb, ta, 1'b0};
			{cc, cb, ca} = r[2:0];
		end
		@(negedge clk);
		{ta, tb, tc, adc} = 4'h0;
		fl[0] = |(fl & 9'h064);
		repeat (3) @(negedge clk);
		chk(sw_flag_rdata, fl);
		// every source pending: serviced one by one in priority order
		fl = 9'h17f;
		ext_flag = 1;
		ext_enable = 1;
		for (i = 0; i < 5; i++)
		begin
			v = vec(fl, 7'h7f, ext_flag);
			wr(fl, 7'h7f);
			take(v, 1);
			take(8'h00, 0);
			fl &= ~svc(v);
			repeat (2) @(negedge clk);
			chk(sw_flag_rdata, fl);
			chk(sw_en_rdata, 7'h7e);
			if (v == `SVIL_VEC_SHARED)
				fl &= ~9'h064;
			ext_flag = ext_flag && v != `SVIL_VEC_EXT;
			if (i == 0)
			begin
				wr(fl, 7'h7f);
				take(8'h00, 0);
			end
			@(negedge clk);
			pop = 1;
			@(negedge clk);
			pop = 0;
		end
		// random flags and enables with global on: one t2 edge decides
		for (i = 0; i < 40; i++)
		begin
			r = $urandom;
			ef = {r[8], 1'b0, r[6:1], r[0] | r[2] | r[5] | r[6]};
			en = {r[14:9], 1'b1};
			ext_flag = r[15];
			wr(ef, en);
			@(negedge clk);
			chk(wake_up, |(ef[6:0] & ~fl[6:0]));
			chk(irq_take, 1'b0);
			v = vec(ef, en, ext_flag && ext_enable);
			take(v, v != 8'h00);
			fl = ef & ~svc(v);
			repeat (2) @(negedge clk);
			chk(sw_flag_rdata, fl);
			chk(sw_en_rdata, en & {6'h3f, v == 8'h00});
			@(negedge clk);
			pop = 1;
			@(negedge clk);
			pop = 0;
		end
		// a flag preset high masks its wake-up; a cleared one wakes
		ext_flag = 0;
		wr(9'h002, 7'h00);
		for (i = 0; i < 2; i++)
		begin
			@(negedge clk);
			ta = 1;
			@(negedge clk);
			ta = 0;
			@(negedge clk);
			chk(wake_up, i == 1);
			wr(9'h000, 7'h00);
		end
		// second reset with the 18h source strapped to the adc
		@(negedge clk);
		rst_n = 0;
		sel_adc = 1;
		{ca, cb, cc} = 3'h0;
		repeat (3) @(negedge clk);
		rst_n = 1;
		chk(sw_flag_rdata, 9'h000);
		chk({irq_take, push_pc, wake_up}, 3'h0);
		@(negedge clk);
		// the strap pin moving after reset must change nothing
		sel_adc = 0;
		for (i = 0; i < 2; i++)
		begin
			{tc, adc} = i == 0 ? 2'b10 : 2'b01;
			@(negedge clk);
			{tc, adc} = 2'b00;
			repeat (3) @(negedge clk);
			chk(sw_flag_rdata, {5'h00, i == 1, 3'h0});
		end
		summarize();
	end
endmodule // tb_top
